// File: rtl/smb_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Slave end: pointer, config register and register port
module smb_dev (
  input wire logic clk_sys,
  input wire logic rst_n,
  smb_if.dev bus,
  input wire logic addr_mode_strap,
  input wire logic addr_sel_strap,
  input wire logic alert_cond,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic alert_n,
  output logic bus_timeout_disable,
  output logic [7:0] bus_and_supply_config
);
  typedef enum logic [2:0] {
    st_idle = 3'b000, st_addr = 3'b001, st_wr = 3'b010, st_rd = 3'b011,
    st_ack = 3'b100, st_rack = 3'b101, st_skip = 3'b110
  } dstate_t;

  logic scl_s, sda_s, scl_d, sda_d;
  smb_sync u_scl (.clk_sys(clk_sys), .rst_n(rst_n), .din(bus.scl), .dout(scl_s));
  smb_sync u_sda (.clk_sys(clk_sys), .rst_n(rst_n), .din(bus.sda), .dout(sda_s));

  logic start_ev, stop_ev, rise, fall;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;

  dstate_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] ptr, next_ptr;
  logic [7:0] cfg, next_cfg;
  logic [1:0] wcount, next_wcount;
  logic ara, next_ara;
  logic sda_oe, next_sda_oe;
  logic [6:0] my_addr, next_my_addr;
  logic latched, next_latched;
  logic [31:0] idle_cnt, next_idle_cnt;
  logic we, next_we;
  logic [7:0] wdata, next_wdata;
  logic alert, next_alert;
  logic [6:0] strap_addr;
  logic [2:0] pin_meta, pin_s;

  // Straps and alert come from pins; reset low so no false alert follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h0;
      pin_s <= 3'h0;
    end else begin
      pin_meta <= {alert_cond, addr_sel_strap, addr_mode_strap};
      pin_s <= pin_meta;
    end
  end

  // Address from straps
  always_comb begin
    if (pin_s[0]) strap_addr = smb_pkg::addr_default;
    else strap_addr = {smb_pkg::addr_upper, 1'b0, pin_s[1]};
  end

  // Protocol engine next state
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_ptr = ptr;
    next_cfg = cfg;
    next_wcount = wcount;
    next_ara = ara;
    next_sda_oe = sda_oe;
    next_my_addr = my_addr;
    next_latched = latched;
    next_we = 1'b0;
    next_wdata = wdata;
    next_idle_cnt = idle_cnt;
    // Alert held while condition is present; cleared when an ARA read byte completes with the condition already gone
    next_alert = alert;
    if (pin_s[2]) next_alert = 1'b1;
    if (rise | fall | state == st_idle) next_idle_cnt = 32'h0;
    else next_idle_cnt = idle_cnt + 32'h1;
    if (start_ev) begin
      // Fresh transaction on start or repeated start
      next_state = st_addr;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_ara = 1'b0;
    end else if (stop_ev) begin
      next_state = st_idle;
      next_sda_oe = 1'b0;
    end else if (!cfg[smb_pkg::bus_timeout_disable_bit] && state != st_idle
                 && idle_cnt >= 32'(smb_pkg::timeout_cycles)) begin
      next_state = st_idle;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        st_idle, st_skip: ;
        st_addr, st_wr: if (rise) begin
          next_shreg = {shreg[6:0], sda_s};
          next_bitcnt = bitcnt + 4'h1;
        end else if (fall && bitcnt == 4'h8) begin
          next_bitcnt = 4'h0;
          if (state == st_addr) begin
            if (shreg[7:1] == smb_pkg::alert_resp_addr && shreg[0] && alert) begin
              next_ara = 1'b1;
              next_sda_oe = 1'b1;
              next_state = st_ack;
              next_shreg = {(latched ? my_addr : strap_addr), 1'b0};
            end else if (shreg[7:1] == (latched ? my_addr : strap_addr)) begin
              if (!latched) next_my_addr = strap_addr;
              next_latched = 1'b1;
              next_sda_oe = 1'b1;
              next_state = st_ack;
              next_wcount = 2'h0;
              next_shreg = ptr_data(ptr, cfg, reg_rdata);
            end else begin
              next_state = st_skip;
            end
            if (shreg[0]) next_wcount = 2'h3;
          end else begin
            next_sda_oe = 1'b1;
            next_state = st_ack;
            if (wcount == 2'h0) begin
              next_ptr = shreg;
              next_wcount = 2'h1;
            end else begin
              next_we = 1'b1;
              next_wdata = shreg;
              if (ptr == smb_pkg::reg_bus_config) next_cfg = shreg;
            end
          end
        end
        st_ack: if (fall) begin
          next_bitcnt = 4'h0;
          if (wcount == 2'h3) begin
            // Read: drive MSB of the loaded byte
            next_state = st_rd;
            next_sda_oe = ~shreg[7];
          end else begin
            next_state = st_wr;
            next_sda_oe = 1'b0;
          end
        end
        st_rd: if (rise) begin
          // Lost arbitration if line low while we release it high
          if (!sda_oe && !sda_s) begin
            next_state = st_skip;
            next_sda_oe = 1'b0;
          end
          next_bitcnt = bitcnt + 4'h1;
        end else if (fall) begin
          next_shreg = {shreg[6:0], 1'b0};
          next_sda_oe = (bitcnt == 4'h8) ? 1'b0 : ~shreg[6];
          if (bitcnt == 4'h8) begin
            next_state = st_rack;
            if (ara && !pin_s[2]) next_alert = 1'b0;
          end
        end
        st_rack: if (rise) next_state = st_skip;
        default: next_state = st_idle;
      endcase
    end
  end

  function automatic logic [7:0] ptr_data(input logic [7:0] p, input logic [7:0] c,
                                          input logic [7:0] d);
    ptr_data = (p == smb_pkg::reg_bus_config) ? c : d;
  endfunction

  // State registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ptr <= 8'h00;
      cfg <= smb_pkg::bus_config_reset;
      wcount <= 2'h0;
      ara <= 1'b0;
      sda_oe <= 1'b0;
      my_addr <= 7'h00;
      latched <= 1'b0;
      idle_cnt <= 32'h0;
      we <= 1'b0;
      wdata <= 8'h00;
      alert <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      ptr <= next_ptr;
      cfg <= next_cfg;
      wcount <= next_wcount;
      ara <= next_ara;
      sda_oe <= next_sda_oe;
      my_addr <= next_my_addr;
      latched <= next_latched;
      idle_cnt <= next_idle_cnt;
      we <= next_we;
      wdata <= next_wdata;
      alert <= next_alert;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign bus.sda_oe_dev = sda_oe;
  assign reg_addr = ptr;
  assign reg_wdata = wdata;
  assign reg_we = we;
  assign alert_n = ~alert;
  assign bus_timeout_disable = cfg[smb_pkg::bus_timeout_disable_bit];
  assign bus_and_supply_config = cfg;
endmodule
`default_nettype wire

// File: rtl/smb_pkg.sv
package smb_pkg;
  localparam logic [4:0] addr_upper = 5'h0B;
  localparam logic [6:0] addr_default = 7'h2E;
  localparam logic [6:0] alert_resp_addr = 7'h0C;
  localparam logic [7:0] reg_bus_config = 8'h40;
  localparam logic [7:0] bus_config_reset = 8'h00;
  localparam int bus_timeout_disable_bit = 6;
  localparam int clk_hz = 25000000;
  localparam int timeout_ms = 35;
  localparam int timeout_cycles = (clk_hz / 1000) * timeout_ms;
  localparam int host_div = 8;
endpackage

// File: rtl/smb_if.sv
`timescale 1ns/1ps
`default_nettype none
// Open-drain bus wires resolved from the enables
interface smb_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport dev (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface
`default_nettype wire

// File: rtl/smb_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for bus pins
module smb_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// File: rtl/smb_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host end: one command per request, SCL from divider
module smb_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  smb_if.host bus,
  input wire logic req,
  input wire logic [6:0] req_addr,
  input wire logic req_read,
  input wire logic [1:0] req_nbytes,
  input wire logic [7:0] req_b0,
  input wire logic [7:0] req_b1,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rdata
);
  typedef enum logic [2:0] {
    h_idle = 3'b000, h_start = 3'b001, h_bit = 3'b010, h_stop = 3'b011, h_end = 3'b100
  } hstate_t;
  logic sda_s;
  smb_sync u_sda (.clk_sys(clk_sys), .rst_n(rst_n), .din(bus.sda), .dout(sda_s));
  hstate_t st, next_st;
  logic [2:0] ph, next_ph;
  logic [3:0] bc, next_bc;
  logic [1:0] bi, next_bi;
  logic [8:0] sh, next_sh;
  logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic busy_r, next_busy, done_r, next_done, nack_r, next_nack;
  logic [7:0] rd, next_rd;
  logic [4:0] cnt;
  logic tick;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 5'h0;
    else cnt <= (cnt == 5'(smb_pkg::host_div - 1)) ? 5'h0 : cnt + 5'h1;
  end
  assign tick = (cnt == 5'h0);
  // Bit phases: 0 SCL low, 1 set data, 2 SCL high, 3 sample
  always_comb begin
    next_st = st; next_ph = ph; next_bc = bc; next_bi = bi; next_sh = sh;
    next_scl_oe = scl_oe; next_sda_oe = sda_oe; next_busy = busy_r;
    next_done = 1'b0; next_nack = nack_r; next_rd = rd;
    unique case (st)
      h_idle: if (req) begin
        next_st = h_start; next_busy = 1'b1; next_nack = 1'b0; next_ph = 3'h0;
        next_sh = {req_addr, req_read, 1'b1}; next_bi = 2'h0; next_bc = 4'h0;
      end
      h_start: if (tick) begin
        next_sda_oe = 1'b1; next_st = h_bit; next_ph = 3'h0;
      end
      h_bit: if (tick) begin
        next_ph = ph + 3'h1;
        if (ph == 3'h0) begin next_scl_oe = 1'b1; end
        if (ph == 3'h1) begin next_sda_oe = ~sh[8]; end
        if (ph == 3'h2) begin next_scl_oe = 1'b0; end
        if (ph == 3'h3) begin
          next_ph = 3'h0;
          next_sh = {sh[7:0], sda_s};
          next_bc = bc + 4'h1;
          if (bc == 4'h8) begin
            next_bc = 4'h0;
            // Eight data bits sit in the low end once the ack slot is reached
            if (bi != 2'h0 && req_read) next_rd = sh[7:0];
            if (sda_s && !(req_read && bi != 2'h0)) begin
              next_nack = 1'b1; next_st = h_stop;
            end else if (bi == req_nbytes) begin
              next_st = h_stop;
            end else begin
              next_bi = bi + 2'h1;
              next_sh = req_read ? 9'h1FF : {(bi == 2'h0) ? req_b0 : req_b1, 1'b1};
              if (req_read && bi + 2'h1 == req_nbytes) next_sh = 9'h1FF;
            end
          end
        end
      end
      h_stop: if (tick) begin
        next_ph = ph + 3'h1;
        if (ph == 3'h0) begin next_sda_oe = 1'b1; next_scl_oe = 1'b1; end
        if (ph == 3'h1) begin next_scl_oe = 1'b0; end
        if (ph == 3'h2) begin next_sda_oe = 1'b0; next_st = h_end; end
      end
      h_end: begin next_busy = 1'b0; next_done = 1'b1; next_st = h_idle; end
      default: next_st = h_idle;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= h_idle; ph <= 3'h0; bc <= 4'h0; bi <= 2'h0; sh <= 9'h1FF;
      scl_oe <= 1'b0; sda_oe <= 1'b0; busy_r <= 1'b0; done_r <= 1'b0;
      nack_r <= 1'b0; rd <= 8'h00;
    end else begin
      st <= next_st; ph <= next_ph; bc <= next_bc; bi <= next_bi; sh <= next_sh;
      scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; busy_r <= next_busy;
      done_r <= next_done; nack_r <= next_nack; rd <= next_rd;
    end
  end
  assign bus.scl_oe_host = scl_oe;
  assign bus.sda_oe_host = sda_oe;
  assign busy = busy_r;
  assign done = done_r;
  assign nack = nack_r;
  assign rdata = rd;
endmodule
`default_nettype wire

// File: sim/smb_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bus wire checks
// ------------------------------
module smb_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Only start and stop may move SDA while SCL is high
  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $rose(sda);
  endsequence
  dev_sda_move_a: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device moved SDA with SCL high");
  scl_low_hold_a: assert property ($fell(scl) |=> !scl [*7])
    else $error("SCL low phase too short");
  scl_high_hold_a: assert property ($rose(scl) |=> scl [*7])
    else $error("SCL high phase too short");
  start_by_host_a: assert property (start_s |-> sda_oe_host)
    else $error("start not made by host");
  start_dev_off_a: assert property (start_s |-> !sda_oe_dev)
    else $error("device drove SDA at start");
  stop_dev_off_a: assert property (stop_s |=> !sda_oe_dev [*8])
    else $error("device drove SDA after stop");
  // Longest legal drive is an ack plus eight zero bits
  dev_drive_bound_a: assert property ($rose(sda_oe_dev) |-> ##[1:400] !sda_oe_dev)
    else $error("device held SDA too long");
  stop_release_a: assert property (stop_s |-> !sda_oe_host && !scl_oe_host)
    else $error("host kept the bus after stop");
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic req_read = 1'b0;
  logic [1:0] req_nbytes = 2'h1;
  logic [7:0] req_b0 = 8'h00;
  logic [7:0] req_b1 = 8'h00;
  logic mode_strap = 1'b1;
  logic sel_strap = 1'b0;
  logic alert_cond = 1'b0;
  logic busy, done, nack, reg_we, alert_n, to_dis;
  logic [7:0] rdata, reg_rdata, reg_addr, reg_wdata, cfg, c, d;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, shf = 8'h00, first_byte = 8'h00;
  logic scl_q = 1'b1, sda_q = 1'b1;
  int nbit = 8, wr_cnt = 0, fails = 0, cmp_count = 0, i;
  smb_if bus_i();
  smb_dev u_smb_dev (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_i),
    .addr_mode_strap(mode_strap), .addr_sel_strap(sel_strap), .alert_cond(alert_cond),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .alert_n(alert_n), .bus_timeout_disable(to_dis), .bus_and_supply_config(cfg));
  smb_host u_smb_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_i), .req(req),
    .req_addr(req_addr), .req_read(req_read), .req_nbytes(req_nbytes), .req_b0(req_b0),
    .req_b1(req_b1), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  smb_props u_smb_props (.clk_sys(clk_sys), .rst_n(rst_n), .scl(bus_i.scl), .sda(bus_i.sda),
    .scl_oe_host(bus_i.scl_oe_host), .sda_oe_host(bus_i.sda_oe_host),
    .sda_oe_dev(bus_i.sda_oe_dev));
  // External registers answer with a scrambled pointer so each address differs
  assign reg_rdata = reg_addr ^ 8'hA5;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Log register writes and shift in the first byte after every start
  always @(posedge clk_sys) begin
    scl_q <= bus_i.scl;
    sda_q <= bus_i.sda;
    if (reg_we === 1'b1) begin
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (scl_q && bus_i.scl && sda_q && !bus_i.sda) begin
      nbit <= 0;
    end else if (!scl_q && bus_i.scl && nbit < 8) begin
      shf <= {shf[6:0], bus_i.sda};
      nbit <= nbit + 1;
      if (nbit == 7) first_byte <= {shf[6:0], bus_i.sda};
    end
  end
  // Request is held until busy shows it was taken
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] n,
      input logic [7:0] b0, input logic [7:0] b1);
    int k;
    k = 0;
    @(posedge clk_sys);
    req <= 1'b1;
    req_addr <= a;
    req_read <= rd;
    req_nbytes <= n;
    req_b0 <= b0;
    req_b1 <= b1;
    do begin
      @(negedge clk_sys);
      k++;
    end while (busy !== 1'b1 && k < 5000);
    @(posedge clk_sys);
    req <= 1'b0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (done !== 1'b1 && k < 5000);
    if (k >= 5000) fails++;
    `chk("addr byte", {a, rd}, first_byte)
  endtask
  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Nineteen transfers take about 13k cycles; allow well over three times that
  initial begin
    #2400000;
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(47328));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    `chk("cfg reset", 8'h00, cfg)
    `chk("timeout dis reset", 1'b0, to_dis)
    `chk("alert idle", 1'b1, alert_n)
    $display("test reset done");
    // Boundary commands first, then random ones clear of the config offset
    for (i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom_range(65, 255));
      d = 8'($urandom());
      xfer(7'h2E, 1'b0, 2'h2, c, d);
      `chk("write ack", 1'b0, nack)
      `chk("write reg", {c, d}, {wr_addr, wr_data})
      xfer(7'h2E, 1'b1, 2'h1, 8'h00, 8'h00);
      `chk("recv byte", c ^ 8'hA5, rdata)
    end
    $display("test write byte done");
    c = 8'($urandom_range(0, 63));
    i = wr_cnt;
    xfer(7'h2E, 1'b0, 2'h1, c, 8'h00);
    `chk("send ptr", c, reg_addr)
    `chk("send no write", i, wr_cnt)
    xfer(7'h2E, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("recv after send", c ^ 8'hA5, rdata)
    xfer(7'h2E, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("pointer kept", c ^ 8'hA5, rdata)
    $display("test send byte done");
    xfer(7'h2E, 1'b0, 2'h2, 8'h40, 8'h40);
    `chk("cfg write", 8'h40, cfg)
    `chk("timeout dis on", 1'b1, to_dis)
    xfer(7'h2E, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("cfg read", 8'h40, rdata)
    xfer(7'h2E, 1'b0, 2'h2, 8'h40, 8'h00);
    `chk("timeout dis off", 1'b0, to_dis)
    $display("test config done");
    // Straps now point at 2D, but the address was already latched
    mode_strap <= 1'b0;
    sel_strap <= 1'b1;
    i = wr_cnt;
    xfer(7'h2D, 1'b0, 2'h2, 8'h12, 8'h34);
    `chk("late strap", 1'b1, nack)
    xfer(7'h2C, 1'b0, 2'h2, 8'h12, 8'h34);
    `chk("foreign nack", 1'b1, nack)
    `chk("foreign no write", i, wr_cnt)
    `chk("foreign ptr", 8'h40, reg_addr)
    $display("test address done");
    xfer(7'h0C, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("ara no alert", 1'b1, nack)
    alert_cond <= 1'b1;
    repeat (5) @(negedge clk_sys);
    `chk("alert set", 1'b0, alert_n)
    xfer(7'h0C, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("ara ack", 1'b0, nack)
    `chk("ara addr", 7'h2E, rdata[7:1])
    `chk("alert held", 1'b0, alert_n)
    alert_cond <= 1'b0;
    xfer(7'h0C, 1'b1, 2'h1, 8'h00, 8'h00);
    `chk("alert clear", 1'b1, alert_n)
    $display("test alert done");
    end_of_test();
  end
endmodule
`default_nettype wire
